// *** hdl/fsio_defs.svh ***
`ifndef FSIO_DEFS_SVH
`define FSIO_DEFS_SVH

// Temperatures in 0.1 degC, current in 0.1 A, voltage in 0.1 V
`define FSIO_OVT_TRIP      16'sh0320
`define FSIO_OVT_CLEAR     16'sh02ee
`define FSIO_BAND          17'sh0000a
`define FSIO_LIMIT_GAP     17'sh0000a
`define FSIO_CUR_MIN       16'h000a
`define FSIO_VOLT_MIN      16'h000a
`define FSIO_VOLT_MAX      16'h01e0
`define FSIO_SENSOR_LO     16'h0010
`define FSIO_SENSOR_HI     16'hfff0

`define FSIO_IN_HIGH_RST   1'b0
`define FSIO_OUT_HIGH_RST  1'b1
`define FSIO_OUT_OC_RST    1'b0
`define FSIO_ENABLE_SW_RST 1'b0

`define FSIO_CLK_KHZ       40000
`define FSIO_FLASH_ON_MS   150
`define FSIO_FLASH_OFF_MS  250
`define FSIO_PAUSE_MS      1500

`endif

// *** hdl/fsio_led_flasher.sv ***
`timescale 1ns/1ps
module fsio_led_flasher #(
  parameter int unsigned ON_CYC    = 6000000,
  parameter int unsigned OFF_CYC   = 10000000,
  parameter int unsigned PAUSE_CYC = 60000000
) (
  input wire logic  sys_clk,
  input wire logic  sys_rst,
  fsio_led_if.flash lf
);
  import fsio_pkg::*;

  if (ON_CYC < 1 || OFF_CYC < 1 || PAUSE_CYC < 1) begin : g_chk
    $error("fsio_led_flasher: cycle counts must be at least 1");
  end

  fsio_phase_t ph_q;
  logic [31:0] cnt_q;
  logic [1:0]  left_q;
  logic        led_q;
  logic        done;

  assign done   = (cnt_q == 32'h0000_0001);
  assign lf.led = led_q;

  // Burst of short flashes, then a long dark pause, repeating
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ph_q   <= FSIO_PH_PAUSE;
      cnt_q  <= 32'h0000_0001;
      left_q <= 2'h0;
    end else if (!done) begin
      cnt_q <= cnt_q - 32'h0000_0001;
    end else begin
      unique case (ph_q)
        FSIO_PH_PAUSE: begin
          if (lf.flash_count != 2'h0) begin
            ph_q   <= FSIO_PH_ON;
            cnt_q  <= ON_CYC;
            left_q <= lf.flash_count - 2'h1;
          end else begin
            cnt_q <= 32'h0000_0001;
          end
        end
        FSIO_PH_ON: begin
          ph_q  <= FSIO_PH_OFF;
          cnt_q <= OFF_CYC;
        end
        FSIO_PH_OFF: begin
          if (left_q == 2'h0) begin
            ph_q  <= FSIO_PH_PAUSE;
            cnt_q <= PAUSE_CYC;
          end else begin
            ph_q   <= FSIO_PH_ON;
            cnt_q  <= ON_CYC;
            left_q <= left_q - 2'h1;
          end
        end
        default: begin
          ph_q  <= FSIO_PH_PAUSE;
          cnt_q <= 32'h0000_0001;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      led_q <= 1'b0;
    end else begin
      led_q <= (ph_q == FSIO_PH_ON);
    end
  end

  property p_led_dark_idle;
    @(posedge sys_clk) disable iff (sys_rst)
      (ph_q == FSIO_PH_PAUSE) |=> !led_q;
  endproperty
  a_led_dark_idle: assert property (p_led_dark_idle)
    else $error("error LED lit during pause");

  property p_burst_len;
    @(posedge sys_clk) disable iff (sys_rst)
      (ph_q == FSIO_PH_PAUSE && done && lf.flash_count != 2'h0)
        |=> left_q == $past(lf.flash_count) - 2'h1;
  endproperty
  a_burst_len: assert property (p_burst_len)
    else $error("flash burst length does not match fault");

endmodule // fsio_led_flasher

// *** hdl/fsio_led_if.sv ***
`timescale 1ns/1ps
interface fsio_led_if;
  logic [1:0] flash_count;
  logic       led;
  modport ctrl  (output flash_count, input led);
  modport flash (input flash_count, output led);
endinterface

// *** hdl/fsio_pkg.sv ***
package fsio_pkg;

  typedef enum logic [1:0] {
    FSIO_IDLE  = 2'h0,
    FSIO_RUN   = 2'h1,
    FSIO_FAULT = 2'h3,
    FSIO_SAFE  = 2'h2
  } fsio_state_t;

  typedef enum logic [1:0] {
    FSIO_PH_PAUSE = 2'h0,
    FSIO_PH_ON    = 2'h1,
    FSIO_PH_OFF   = 2'h3
  } fsio_phase_t;

  typedef enum logic [1:0] {
    FSIO_TS_OFF  = 2'h0,
    FSIO_TS_OK   = 2'h1,
    FSIO_TS_HIGH = 2'h2,
    FSIO_TS_LOW  = 2'h3
  } fsio_temp_stat_t;

endpackage

// *** hdl/fsio_top.sv ***
`timescale 1ns/1ps
`include "fsio_defs.svh"
module fsio_top #(
  parameter logic [15:0] SENSOR_LO     = `FSIO_SENSOR_LO,
  parameter logic [15:0] SENSOR_HI     = `FSIO_SENSOR_HI,
  parameter int unsigned FLASH_ON_CYC  = `FSIO_FLASH_ON_MS * `FSIO_CLK_KHZ,
  parameter int unsigned FLASH_OFF_CYC = `FSIO_FLASH_OFF_MS * `FSIO_CLK_KHZ,
  parameter int unsigned PAUSE_CYC     = `FSIO_PAUSE_MS * `FSIO_CLK_KHZ
) (
  input  wire logic               sys_clk,
  input  wire logic               sys_rst,
  input  wire logic               external_activate_input,
  input  wire logic               external_fault_clear_input,
  input  wire logic               short_circuit_trip,
  input  wire logic [15:0]        sensor_raw,
  input  wire logic signed [15:0] sensor_temp,
  input  wire logic signed [15:0] setpoint_temp,
  input  wire logic signed [15:0] stage_temp,
  input  wire logic               host_start,
  input  wire logic               host_stop,
  input  wire logic               host_fault_reset,
  input  wire logic               cfg_write,
  input  wire logic               cfg_enable_sw,
  input  wire logic signed [15:0] cfg_temp_min,
  input  wire logic signed [15:0] cfg_temp_max,
  input  wire logic [15:0]        cfg_current_limit,
  input  wire logic [15:0]        cfg_voltage_limit,
  input  wire logic               io_cfg_write,
  input  wire logic               io_in_active_high,
  input  wire logic               io_out_active_high,
  input  wire logic               io_out_open_collector,
  output logic                    run_enable,
  output logic                    power_zero,
  output logic                    ready_out,
  output logic                    ready_oe,
  output logic                    error_led,
  output logic [2:0]              fault_flags,
  output logic                    activate_input_status,
  output fsio_pkg::fsio_temp_stat_t temp_status,
  output logic                    safe_state,
  output logic                    cfg_rejected,
  output logic                    enable_sw,
  output logic signed [15:0]      lim_temp_min,
  output logic signed [15:0]      lim_temp_max,
  output logic [15:0]             lim_current,
  output logic [15:0]             lim_voltage
);
  import fsio_pkg::*;

  if (SENSOR_LO >= SENSOR_HI) begin : g_chk
    $error("fsio_top: sensor range is empty");
  end

  // Synchroniser: bit 0 activate, 1 fault clear, 2 short-circuit trip
  logic [2:0] pin_raw;
  logic [2:0] s1_q;
  logic [2:0] s2_q;
  logic [2:0] s3_q;
  logic [2:0] filt_q;
  // Reset to the idle pin level, else a false activate follows reset
  localparam logic [2:0] SYNC_IDLE = {1'b0, {2{~`FSIO_IN_HIGH_RST}}};

  assign pin_raw = {short_circuit_trip, external_fault_clear_input,
                    external_activate_input};

  for (genvar i = 0; i < 3; i++) begin : g_sync
    always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
        s1_q[i]   <= SYNC_IDLE[i];
        s2_q[i]   <= SYNC_IDLE[i];
        s3_q[i]   <= SYNC_IDLE[i];
        filt_q[i] <= SYNC_IDLE[i];
      end else begin
        s1_q[i] <= pin_raw[i];
        s2_q[i] <= s1_q[i];
        s3_q[i] <= s2_q[i];
        if (s2_q[i] == s3_q[i]) begin
          filt_q[i] <= s3_q[i];
        end
      end
    end
  end

  // IO polarity and drive configuration
  logic in_high_q;
  logic out_high_q;
  logic out_oc_q;
  fsio_state_t state_q;
  fsio_state_t state_d;
  logic idle_ok;
  logic io_accept;

  assign idle_ok   = (state_q == FSIO_IDLE) || (state_q == FSIO_FAULT);
  assign io_accept = io_cfg_write && idle_ok;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      in_high_q  <= `FSIO_IN_HIGH_RST;
      out_high_q <= `FSIO_OUT_HIGH_RST;
      out_oc_q   <= `FSIO_OUT_OC_RST;
    end else if (io_accept) begin
      in_high_q  <= io_in_active_high;
      out_high_q <= io_out_active_high;
      out_oc_q   <= io_out_open_collector;
    end
  end

  logic act_lvl;
  logic clr_lvl;
  logic clr_prev_q;
  logic clr_edge;
  logic clear_req;

  assign act_lvl  = filt_q[0] ~^ in_high_q;
  assign clr_lvl  = filt_q[1] ~^ in_high_q;
  assign clr_edge = clr_lvl && !clr_prev_q;
  // Pin clear needs the activate input released first; host_fault_reset does not
  assign clear_req = (clr_edge && !act_lvl) || host_fault_reset;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      clr_prev_q <= 1'b0;
    end else begin
      clr_prev_q <= clr_lvl;
    end
  end

  // Fault flags: 0 sensor, 1 overtemperature, 2 short circuit
  logic [2:0] flags_q;
  logic [2:0] flags_d;
  logic [2:0] set_vec;
  logic [2:0] clr_mask;
  logic       ovt_cool;

  assign set_vec[0] = (sensor_raw < SENSOR_LO) ||
                      (sensor_raw > SENSOR_HI);
  assign set_vec[1] = stage_temp > `FSIO_OVT_TRIP;
  assign set_vec[2] = filt_q[2];
  assign ovt_cool   = stage_temp < `FSIO_OVT_CLEAR;
  assign clr_mask   = {3{clear_req}} & {1'b1, ovt_cool, 1'b1};
  // Set beats clear; flags hold after the cause is gone
  assign flags_d    = set_vec | (flags_q & ~clr_mask);

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      flags_q <= 3'h0;
    end else begin
      flags_q <= flags_d;
    end
  end

  // Operating configuration and limits
  logic               enable_sw_q;
  logic signed [15:0] tmin_q;
  logic signed [15:0] tmax_q;
  logic [15:0]        cur_q;
  logic [15:0]        volt_q;
  logic               cfg_valid;
  logic               cfg_accept;
  logic               cfg_rej_q;

  assign cfg_valid =
    (17'(cfg_temp_min) <= 17'(cfg_temp_max) - `FSIO_LIMIT_GAP) &&
    (cfg_current_limit >= `FSIO_CUR_MIN) &&
    (cfg_voltage_limit >= `FSIO_VOLT_MIN) &&
    (cfg_voltage_limit <= `FSIO_VOLT_MAX);
  assign cfg_accept = cfg_write && idle_ok && cfg_valid;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      enable_sw_q <= `FSIO_ENABLE_SW_RST;
      tmin_q      <= 16'sh0000;
      tmax_q      <= 16'sh01f4;
      cur_q       <= `FSIO_CUR_MIN;
      volt_q      <= `FSIO_VOLT_MAX;
    end else if (cfg_accept) begin
      enable_sw_q <= cfg_enable_sw;
      tmin_q      <= cfg_temp_min;
      tmax_q      <= cfg_temp_max;
      cur_q       <= cfg_current_limit;
      volt_q      <= cfg_voltage_limit;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cfg_rej_q <= 1'b0;
    end else begin
      cfg_rej_q <= cfg_write && !cfg_accept;
    end
  end

  // Software start latch; ignored in hardware mode or while faulted
  logic start_q;
  logic permit;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      start_q <= 1'b0;
    end else if (!enable_sw_q || host_stop || !act_lvl ||
                 (|flags_d) || state_q == FSIO_SAFE) begin
      start_q <= 1'b0;
    end else if (host_start) begin
      start_q <= 1'b1;
    end
  end

  assign permit = act_lvl && (!enable_sw_q || start_q);

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      FSIO_SAFE: state_d = FSIO_SAFE;
      default: begin
        if (io_accept) begin
          state_d = FSIO_SAFE;
        end else if (|flags_d) begin
          state_d = FSIO_FAULT;
        end else if (permit) begin
          state_d = FSIO_RUN;
        end else begin
          state_d = FSIO_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_q <= FSIO_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Registered outputs
  logic            run_q;
  logic            zero_q;
  logic            safe_q;
  logic            rdy_o_q;
  logic            rdy_oe_q;
  logic            act_st_q;
  fsio_temp_stat_t ts_q;
  logic            rdy_lvl;
  logic signed [16:0] tdiff;

  assign rdy_lvl = (state_d == FSIO_RUN) ~^ out_high_q;
  assign tdiff   = 17'(sensor_temp) - 17'(setpoint_temp);

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      run_q  <= 1'b0;
      zero_q <= 1'b1;
      safe_q <= 1'b0;
    end else begin
      run_q  <= (state_d == FSIO_RUN);
      zero_q <= (state_d != FSIO_RUN);
      safe_q <= (state_d == FSIO_SAFE);
    end
  end

  // Open collector only sinks; the pin floats for a high level
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rdy_o_q  <= 1'b0;
      rdy_oe_q <= 1'b1;
    end else begin
      rdy_o_q  <= out_oc_q ? 1'b0 : rdy_lvl;
      rdy_oe_q <= out_oc_q ? !rdy_lvl : 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      act_st_q <= 1'b0;
      ts_q     <= FSIO_TS_OFF;
    end else begin
      act_st_q <= act_lvl;
      if (state_d != FSIO_RUN) begin
        ts_q <= FSIO_TS_OFF;
      end else if (tdiff > `FSIO_BAND) begin
        ts_q <= FSIO_TS_HIGH;
      end else if (tdiff < -`FSIO_BAND) begin
        ts_q <= FSIO_TS_LOW;
      end else begin
        ts_q <= FSIO_TS_OK;
      end
    end
  end

  // Error LED code; sensor has priority, then short, then overtemp
  fsio_led_if led_if ();
  logic [1:0] flash_q;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      flash_q <= 2'h0;
    end else if (flags_q[0]) begin
      flash_q <= 2'h1;
    end else if (flags_q[2]) begin
      flash_q <= 2'h2;
    end else if (flags_q[1]) begin
      flash_q <= 2'h3;
    end else begin
      flash_q <= 2'h0;
    end
  end

  assign led_if.flash_count = flash_q;

  fsio_led_flasher #(
    .ON_CYC    (FLASH_ON_CYC),
    .OFF_CYC   (FLASH_OFF_CYC),
    .PAUSE_CYC (PAUSE_CYC)
  ) u_flasher (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .lf      (led_if.flash)
  );

  assign run_enable            = run_q;
  assign power_zero            = zero_q;
  assign ready_out             = rdy_o_q;
  assign ready_oe              = rdy_oe_q;
  assign error_led             = led_if.led;
  assign fault_flags           = flags_q;
  assign activate_input_status = act_st_q;
  assign temp_status           = ts_q;
  assign safe_state            = safe_q;
  assign cfg_rejected          = cfg_rej_q;
  assign enable_sw             = enable_sw_q;
  assign lim_temp_min          = tmin_q;
  assign lim_temp_max          = tmax_q;
  assign lim_current           = cur_q;
  assign lim_voltage           = volt_q;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  property p_fault_stop;
    (|flags_d) |=> !run_q && zero_q;
  endproperty
  a_fault_stop: assert property (p_fault_stop)
    else $error("power stage not zeroed on fault");

  property p_ready_off;
    (|flags_q && !out_oc_q && out_high_q) |-> !rdy_o_q;
  endproperty
  a_ready_off: assert property (p_ready_off)
    else $error("ready active while faulted");

  property p_no_enable;
    (|flags_q) && !clear_req && (host_start || act_lvl) |=> !run_q;
  endproperty
  a_no_enable: assert property (p_no_enable)
    else $error("enabled while faulted");

  sequence s_pin_clear;
    !act_lvl && clr_edge;
  endsequence
  property p_pin_clear;
    s_pin_clear ##0 (flags_q != 3'h0 && set_vec == 3'h0 && ovt_cool)
      |=> flags_q == 3'h0;
  endproperty
  a_pin_clear: assert property (p_pin_clear)
    else $error("fault not cleared by clear input");

  property p_ovt_hold;
    flags_q[1] && !ovt_cool |=> flags_q[1];
  endproperty
  a_ovt_hold: assert property (p_ovt_hold)
    else $error("overtemperature cleared while hot");

  property p_latch;
    flags_q[2] && !clear_req |=> flags_q[2];
  endproperty
  a_latch: assert property (p_latch)
    else $error("fault flag dropped without clear");

  property p_hw_start;
    !enable_sw_q |=> !start_q;
  endproperty
  a_hw_start: assert property (p_hw_start)
    else $error("start latched in hardware mode");

  property p_permit;
    enable_sw_q && !start_q |=> !run_q;
  endproperty
  a_permit: assert property (p_permit)
    else $error("software mode ran without start");

  property p_cfg_locked;
    cfg_write && state_q == FSIO_RUN |=> $stable(cur_q) && cfg_rej_q;
  endproperty
  a_cfg_locked: assert property (p_cfg_locked)
    else $error("configuration changed while enabled");

  sequence s_io_change;
    io_cfg_write && idle_ok;
  endsequence
  property p_safe;
    s_io_change |=> (state_q == FSIO_SAFE) [*4] ##0 !run_q;
  endproperty
  a_safe: assert property (p_safe)
    else $error("safe state left after IO change");

endmodule // fsio_top

// *** testbench/fsio_ext_model.sv ***
`timescale 1ns/1ps
module fsio_ext_model (
  input  wire logic sys_clk,
  input  wire logic in_active_high,
  input  wire logic act,
  input  wire logic clr,
  input  wire logic force_clr,
  output logic      external_activate_input,
  output logic      external_fault_clear_input
);
  logic act_q = 1'b0;
  logic clr_eff;

  // Clear waits one cycle after activate drops, unless forced
  always_ff @(posedge sys_clk) begin
    act_q <= act;
  end

  assign clr_eff = clr & ((~act & ~act_q) | force_clr);
  // Pins idle at the inactive level of the chosen polarity
  assign external_activate_input    = in_active_high ? act : ~act;
  assign external_fault_clear_input = in_active_high ? clr_eff : ~clr_eff;
endmodule // fsio_ext_model

// *** testbench/testbench.sv ***
`timescale 1ns/1ps
module testbench;
  import fsio_pkg::*;
  logic sys_clk, sys_rst, short_circuit_trip, cfg_write, cfg_enable_sw;
  logic io_cfg_write, io_in_active_high, io_out_active_high;
  logic io_out_open_collector, pol, act, clr, force_clr;
  logic external_activate_input, external_fault_clear_input;
  logic [15:0] sensor_raw, cfg_current_limit, cfg_voltage_limit;
  logic signed [15:0] sensor_temp, setpoint_temp, stage_temp;
  logic signed [15:0] cfg_temp_min, cfg_temp_max;
  logic signed [15:0] lim_temp_min, lim_temp_max;
  logic [15:0] lim_current, lim_voltage;
  logic [2:0] hp, fault_flags;
  logic run_enable, power_zero, ready_out, ready_oe, error_led;
  logic activate_input_status, safe_state, cfg_rejected, enable_sw;
  fsio_temp_stat_t temp_status;
  wire host_start       = hp[0];
  wire host_stop        = hp[1];
  wire host_fault_reset = hp[2];
  int n_mismatch = 0;
  int tests_run = 0;
  int cyc = 0;

  fsio_top #(.FLASH_ON_CYC(3), .FLASH_OFF_CYC(3), .PAUSE_CYC(10))
    fsio_top_inst (
    .sys_clk, .sys_rst, .external_activate_input,
    .external_fault_clear_input, .short_circuit_trip, .sensor_raw,
    .sensor_temp, .setpoint_temp, .stage_temp, .host_start, .host_stop,
    .host_fault_reset, .cfg_write, .cfg_enable_sw, .cfg_temp_min,
    .cfg_temp_max, .cfg_current_limit, .cfg_voltage_limit, .io_cfg_write,
    .io_in_active_high, .io_out_active_high, .io_out_open_collector,
    .run_enable, .power_zero, .ready_out, .ready_oe, .error_led,
    .fault_flags, .activate_input_status, .temp_status, .safe_state,
    .cfg_rejected, .enable_sw, .lim_temp_min, .lim_temp_max, .lim_current,
    .lim_voltage
  );

  fsio_ext_model fsio_ext_model_inst (
    .sys_clk, .in_active_high(pol), .act, .clr, .force_clr,
    .external_activate_input, .external_fault_clear_input
  );

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // Generous ceiling: the full run needs well under 3000 cycles
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 8000) begin
      n_mismatch++;
      test_done();
    end
  end

  task automatic tick(input int k);
    repeat (k) begin
      @(posedge sys_clk);
      #2;
    end
  endtask

  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic pulse(input logic [2:0] v);
    hp = v;
    tick(1);
    hp = 3'h0;
    tick(3);
  endtask

  task automatic cfg(input logic [15:0] mn, input logic [15:0] mx,
                     input logic [15:0] cu, input logic [15:0] vo,
                     input logic sw, input logic rej);
    cfg_temp_min = mn;
    cfg_temp_max = mx;
    cfg_current_limit = cu;
    cfg_voltage_limit = vo;
    cfg_enable_sw = sw;
    cfg_write = 1'b1;
    tick(1);
    chk("cfg_rejected", {15'h0, rej}, {15'h0, cfg_rejected});
    cfg_write = 1'b0;
    tick(2);
  endtask

  // Count flashes in one burst: bursts are split by long dark pauses
  task automatic flashes(input logic [15:0] e);
    int dark;
    int f;
    dark = 0;
    f = 0;
    for (int i = 0; i < 300 && dark < 8; i++) begin
      tick(1);
      dark = error_led ? 0 : dark + 1;
    end
    // Already in a dark stretch, so a flash at once still counts
    dark = 1;
    for (int i = 0; i < 300 && dark < 8; i++) begin
      tick(1);
      if (error_led === 1'b1 && dark > 0) f++;
      dark = error_led ? 0 : dark + 1;
    end
    chk("flash_count", e, f[15:0]);
  endtask

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  logic [15:0] raw_tab [4] = '{16'h000f, 16'h0010, 16'hfff0, 16'hfff1};
  logic signed [15:0] off_tab [4] = '{16'sh000a, 16'sh000b, 16'shfff6,
                                      16'shfff5};
  fsio_temp_stat_t ts_tab [4] = '{FSIO_TS_OK, FSIO_TS_HIGH, FSIO_TS_OK,
                                  FSIO_TS_LOW};

  initial begin
    sys_rst = 1'b1;
    {short_circuit_trip, cfg_write, cfg_enable_sw, io_cfg_write} = 4'h0;
    {io_in_active_high, io_out_active_high} = 2'h1;
    {io_out_open_collector, pol, act, clr, force_clr, hp} = 8'h0;
    sensor_raw = 16'h8000;
    {sensor_temp, setpoint_temp, stage_temp} = {3{16'sh00fa}};
    {cfg_temp_min, cfg_temp_max} = 32'h0;
    {cfg_current_limit, cfg_voltage_limit} = 32'h0;
    tick(6);
    sys_rst = 1'b0;
    tick(4);
    chk("ready_out", 16'h0, {15'h0, ready_out});
    chk("ready_oe", 16'h1, {15'h0, ready_oe});
    chk("act_status", 16'h0, {15'h0, activate_input_status});
    chk("lim_voltage", 16'h01e0, lim_voltage);
    $display("test reset done");
    act = 1'b1;
    tick(8);
    chk("act_status", 16'h1, {15'h0, activate_input_status});
    chk("run_enable", 16'h1, {15'h0, run_enable});
    chk("ready_out", 16'h1, {15'h0, ready_out});
    for (int i = 0; i < 4; i++) begin
      sensor_temp = setpoint_temp + off_tab[i];
      tick(3);
      chk("temp_status", {14'h0, ts_tab[i]}, {14'h0, temp_status});
    end
    cfg(16'h0, 16'h01f4, 16'h000a, 16'h01e0, 1'b0, 1'b1);
    $display("test hardware run done");
    short_circuit_trip = 1'b1;
    tick(6);
    chk("fault_flags", 16'h4, {13'h0, fault_flags});
    chk("power_zero", 16'h1, {15'h0, power_zero});
    chk("ready_out", 16'h0, {15'h0, ready_out});
    chk("temp_status", {14'h0, FSIO_TS_OFF}, {14'h0, temp_status});
    chk("run_enable", 16'h0, {15'h0, run_enable});
    short_circuit_trip = 1'b0;
    {clr, force_clr} = 2'h3;
    tick(8);
    {clr, force_clr} = 2'h0;
    tick(8);
    chk("fault_flags", 16'h4, {13'h0, fault_flags});
    flashes(16'h2);
    act = 1'b0;
    tick(2);
    clr = 1'b1;
    tick(8);
    clr = 1'b0;
    tick(8);
    chk("fault_flags", 16'h0, {13'h0, fault_flags});
    $display("test short circuit done");
    stage_temp = 16'sh0320;
    tick(4);
    chk("fault_flags", 16'h0, {13'h0, fault_flags});
    stage_temp = 16'sh0321;
    tick(4);
    chk("fault_flags", 16'h2, {13'h0, fault_flags});
    flashes(16'h3);
    stage_temp = 16'sh02ee;
    pulse(3'h4);
    chk("fault_flags", 16'h2, {13'h0, fault_flags});
    stage_temp = 16'sh02ed;
    pulse(3'h4);
    chk("fault_flags", 16'h0, {13'h0, fault_flags});
    $display("test overtemperature done");
    for (int i = 0; i < 4; i++) begin
      sensor_raw = raw_tab[i];
      tick(4);
      chk("sensor_fault", {15'h0, i[0] == i[1]},
          {15'h0, fault_flags[0]});
      if (i == 0) flashes(16'h1);
      sensor_raw = 16'h8000;
      pulse(3'h4);
    end
    $display("test sensor done");
    cfg(16'h0, 16'h0009, 16'h000a, 16'h01e0, 1'b0, 1'b1);
    cfg(16'hfff6, 16'h0, 16'h000b, 16'h01e0, 1'b0, 1'b0);
    chk("lim_temp_max", 16'h0000, lim_temp_max);
    chk("lim_temp_min", 16'hfff6, lim_temp_min);
    chk("lim_current", 16'h000b, lim_current);
    cfg(16'h0, 16'h01f4, 16'h0009, 16'h01e0, 1'b0, 1'b1);
    cfg(16'h0, 16'h01f4, 16'h000a, 16'h0009, 1'b0, 1'b1);
    cfg(16'h0, 16'h01f4, 16'h000a, 16'h01e1, 1'b0, 1'b1);
    cfg(16'h0, 16'h01f4, 16'h000a, 16'h000a, 1'b1, 1'b0);
    chk("lim_voltage", 16'h000a, lim_voltage);
    chk("enable_sw", 16'h1, {15'h0, enable_sw});
    $display("test limits done");
    act = 1'b1;
    tick(8);
    chk("run_enable", 16'h0, {15'h0, run_enable});
    pulse(3'h1);
    chk("run_enable", 16'h1, {15'h0, run_enable});
    pulse(3'h2);
    chk("run_enable", 16'h0, {15'h0, run_enable});
    short_circuit_trip = 1'b1;
    tick(6);
    short_circuit_trip = 1'b0;
    pulse(3'h1);
    chk("run_enable", 16'h0, {15'h0, run_enable});
    act = 1'b0;
    tick(8);
    pulse(3'h4);
    cfg(16'h0, 16'h01f4, 16'h000a, 16'h01e0, 1'b0, 1'b0);
    pulse(3'h1);
    chk("run_enable", 16'h0, {15'h0, run_enable});
    $display("test software mode done");
    {io_in_active_high, io_out_active_high, io_out_open_collector} = 3'h5;
    io_cfg_write = 1'b1;
    tick(1);
    io_cfg_write = 1'b0;
    tick(2);
    chk("safe_state", 16'h1, {15'h0, safe_state});
    pol = 1'b1;
    act = 1'b1;
    tick(8);
    chk("act_status", 16'h1, {15'h0, activate_input_status});
    chk("run_enable", 16'h0, {15'h0, run_enable});
    chk("ready_out", 16'h0, {15'h0, ready_out});
    chk("ready_oe", 16'h0, {15'h0, ready_oe});
    sys_rst = 1'b1;
    {pol, act} = 2'h0;
    tick(6);
    sys_rst = 1'b0;
    tick(2);
    chk("safe_state", 16'h0, {15'h0, safe_state});
    $display("test io config done");
    test_done();
  end
endmodule // testbench
